// ===== pkg/pce_params.svh
/*
 * offsets, field positions, reset values and the unlock key of the
 * power-controller register slice; assumes 8-bit register addresses.
 */
`ifndef PCE_PARAMS_SVH
`define PCE_PARAMS_SVH

`define PCE_ADDR_CTRL 8'h06
`define PCE_ADDR_FLAGS 8'h07
`define PCE_ADDR_KEY 8'h10
`define PCE_ADDR_ENABLE 8'h11

`define PCE_CTRL_ACQ_BIT 0
`define PCE_CTRL_PFSD_BIT 1
`define PCE_EN_RAIL5_BIT 4
`define PCE_EN_RAIL6_BIT 5
`define PCE_EN_WIDTH 6
`define PCE_SEQ_WIDTH 5

`define PCE_RST_CTRL 8'h00
`define PCE_RST_FLAGS 8'h00
`define PCE_RST_ENABLE 6'h00
`define PCE_KEY_READBACK 8'h00

// arbitrary unlock value
`define PCE_UNLOCK_VALUE 8'h5A

`endif

// ===== pkg/pce_pkg.sv
/*
 * types of the power-controller register slice;
 * assumes pce_params.svh supplies the numbers.
 */
`default_nettype none
package pce_pkg;
    typedef logic [7:0] pce_byte_t;
    typedef enum logic [1:0] {
        PCE_PWR_ACTIVE = 2'h1,
        PCE_PWR_OFF = 2'h2
    } pce_pwr_e;
endpackage : pce_pkg
`default_nettype wire

// ===== logic/pce_regs.sv
/*
 * control, resume-flag, unlock-key and rail-enable registers of the
 * power controller. assumes the serial front end presents one-cycle
 * read and write strobes on this clock, and that the sequencer, wake
 * logic and seal state come from logic on the same clock.
 */
`default_nettype none
`include "pce_params.svh"

// Notes on behaviour
// - shutdown enabled and power-fail output low: all rails off, off state
// - shutdown disabled: power-fail output leaves controller state alone
// - writing 1 to acquire bit starts measurement; self-clears; 0 ignored
// - general output flags read 1 after suspend wake with output enabled
// - linear and rail 4 flags set on suspend wake, cleared from off
// - buck rail 1-3 flags read 1 only after suspend wake with rail enabled
// - flag register is read-only and resets to zero
// - unlock key register always reads zero
// - writing the unlock value to the key register grants access to protected enable register
// - enable bits 5..0 drive rails 6..1; bits 7-6 read zero
// - sequencer updates rail 1-5 enables by itself during sequencing
// - clearing rail 5 or 6 enable by a register write works only while seal reads 0
// - seal reads 0 while intact, 1 once broken
module pce_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port from the serial front end
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // power-fail comparator pin
    input wire logic power_fail_out_n,
    // sequencer, wake and seal state
    input wire logic seq_update,
    input wire logic [4:0] seq_rail_en,
    input wire logic wake_pulse,
    input wire logic wake_from_suspend,
    input wire logic [7:0] suspend_en_snapshot,
    input wire logic freshness_seal,
    // controls out
    output logic [5:0] rail_enable,
    output logic cell_acquire_start,
    output logic power_off,
    output logic unlocked
);

    logic pf_s1_reg, pf_s2_reg, pf_s3_reg, pf_n_reg, pf_n_next;
    logic pfsd_reg, pfsd_next, acq_reg, acq_next;
    logic unlock_reg, unlock_next;
    logic [7:0] flags_reg, flags_next;
    logic [5:0] en_reg, en_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    pce_pkg::pce_pwr_e pwr_reg, pwr_next;
    logic off_reg, off_next;
    logic trip;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    // three stages; only the last two are compared
    always_ff @(posedge clock) begin
        if (rst) begin
            pf_s1_reg <= 1'b1;
            pf_s2_reg <= 1'b1;
            pf_s3_reg <= 1'b1;
        end else begin
            pf_s1_reg <= power_fail_out_n;
            pf_s2_reg <= pf_s1_reg;
            pf_s3_reg <= pf_s2_reg;
        end
    end

    always_comb begin
        pf_n_next = pf_n_reg;
        if (pf_s2_reg == pf_s3_reg) begin
            pf_n_next = pf_s3_reg;
        end
    end

    assign trip = pfsd_reg & ~pf_n_reg;

    always_comb begin
        pfsd_next = pfsd_reg;
        acq_next = 1'b0;
        unlock_next = unlock_reg;
        flags_next = flags_reg;
        en_next = en_reg;
        pwr_next = pwr_reg;
        if (reg_wr && hit(reg_addr, `PCE_ADDR_CTRL)) begin
            pfsd_next = reg_wdata[`PCE_CTRL_PFSD_BIT];
            // a new 1 beats the self-clear of the previous request
            acq_next = reg_wdata[`PCE_CTRL_ACQ_BIT];
        end
        if (reg_wr) begin
            // key is one-shot: any write after the key relocks
            unlock_next = hit(reg_addr, `PCE_ADDR_KEY) &&
                hit(reg_wdata, `PCE_UNLOCK_VALUE);
        end
        if (reg_wr && hit(reg_addr, `PCE_ADDR_ENABLE) && unlock_reg) begin
            en_next = reg_wdata[`PCE_EN_WIDTH-1:0];
            if (freshness_seal) begin
                en_next[`PCE_EN_RAIL5_BIT] = reg_wdata[`PCE_EN_RAIL5_BIT] |
                    en_reg[`PCE_EN_RAIL5_BIT];
                en_next[`PCE_EN_RAIL6_BIT] = reg_wdata[`PCE_EN_RAIL6_BIT] |
                    en_reg[`PCE_EN_RAIL6_BIT];
            end
        end
        if (seq_update) begin
            en_next[`PCE_SEQ_WIDTH-1:0] = seq_rail_en;
        end
        if (wake_pulse) begin
            // snapshot order matches flag bit order
            flags_next = wake_from_suspend ? suspend_en_snapshot :
                `PCE_RST_FLAGS;
        end
        unique case (pwr_reg)
            pce_pkg::PCE_PWR_ACTIVE: begin
                if (trip) begin
                    pwr_next = pce_pkg::PCE_PWR_OFF;
                end
            end
            pce_pkg::PCE_PWR_OFF: begin
                if (wake_pulse && !trip) begin
                    pwr_next = pce_pkg::PCE_PWR_ACTIVE;
                end
            end
            default: pwr_next = pce_pkg::PCE_PWR_OFF;
        endcase
        if (trip) begin
            en_next = `PCE_RST_ENABLE;
        end
        // registered decode so the off output never glitches
        off_next = (pwr_next == pce_pkg::PCE_PWR_OFF);
    end

    always_comb begin
        rvalid_next = reg_rd;
        rdata_next = 8'h00;
        if (reg_rd) begin
            unique case (1'b1)
                hit(reg_addr, `PCE_ADDR_CTRL):
                    rdata_next = {6'h00, pfsd_reg, acq_reg};
                hit(reg_addr, `PCE_ADDR_FLAGS):
                    rdata_next = flags_reg;
                hit(reg_addr, `PCE_ADDR_KEY):
                    rdata_next = `PCE_KEY_READBACK;
                hit(reg_addr, `PCE_ADDR_ENABLE):
                    rdata_next = {2'h0, en_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pf_n_reg <= 1'b1;
            pfsd_reg <= 1'(`PCE_RST_CTRL >> `PCE_CTRL_PFSD_BIT);
            acq_reg <= 1'b0;
            unlock_reg <= 1'b0;
            flags_reg <= `PCE_RST_FLAGS;
            en_reg <= `PCE_RST_ENABLE;
            pwr_reg <= pce_pkg::PCE_PWR_ACTIVE;
            off_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            pf_n_reg <= pf_n_next;
            pfsd_reg <= pfsd_next;
            acq_reg <= acq_next;
            unlock_reg <= unlock_next;
            flags_reg <= flags_next;
            en_reg <= en_next;
            pwr_reg <= pwr_next;
            off_reg <= off_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign rail_enable = en_reg;
    assign cell_acquire_start = acq_reg;
    assign power_off = off_reg;
    assign unlocked = unlock_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_TRIP_OFF: assert property (
        trip |=> (en_reg == 6'h00) && power_off)
        else $error("trip did not shut rails off");
    AST_NO_TRIP: assert property (
        !pfsd_reg && !power_off && !wake_pulse |=> !power_off)
        else $error("power fail acted while disabled");
    AST_ACQ_PULSE: assert property (
        acq_reg && !(reg_wr && hit(reg_addr, `PCE_ADDR_CTRL)) |=> !acq_reg)
        else $error("acquire bit did not self-clear");
    AST_ACQ_START: assert property (
        reg_wr && hit(reg_addr, `PCE_ADDR_CTRL) && reg_wdata[0] |=> acq_reg)
        else $error("acquire write lost");
    AST_FLAG_WAKE: assert property (
        wake_pulse && wake_from_suspend |=>
        flags_reg == $past(suspend_en_snapshot))
        else $error("flags differ from suspend snapshot");
    AST_FLAG_OFF: assert property (
        wake_pulse && !wake_from_suspend |=> flags_reg == 8'h00)
        else $error("flags not cleared on wake from off");
    AST_FLAG_HOLD: assert property (
        !wake_pulse |=> $stable(flags_reg))
        else $error("flags changed without wake");
    AST_KEY_ZERO: assert property (
        reg_rd && hit(reg_addr, `PCE_ADDR_KEY) |=> reg_rvalid &&
        reg_rdata == 8'h00)
        else $error("key readback not zero");
    AST_LOCKED: assert property (
        reg_wr && hit(reg_addr, `PCE_ADDR_ENABLE) && !unlock_reg &&
        !seq_update && !trip |=> $stable(en_reg))
        else $error("locked write changed enables");
    AST_SEAL: assert property (
        freshness_seal && en_reg[5] && !trip |=> en_reg[5])
        else $error("rail 6 cleared with seal broken");
    AST_SEQ: assert property (
        seq_update && !trip |=> en_reg[4:0] == $past(seq_rail_en))
        else $error("sequencer update lost");
    AST_RSV: assert property (
        reg_rd && hit(reg_addr, `PCE_ADDR_ENABLE) |=> reg_rdata[7:6] == 2'h0)
        else $error("reserved enable bits not zero");

    CV_TRIP: cover property (trip ##1 power_off);
    CV_UNLOCK_WR: cover property (unlock_reg && reg_wr &&
        hit(reg_addr, `PCE_ADDR_ENABLE));
    CV_WAKE: cover property (wake_pulse && wake_from_suspend);
    CV_ACQ: cover property (acq_reg);

endmodule : pce_regs
`default_nettype wire

// ===== tb/pce_host_model.sv
/*
 * host side of the register port: one-cycle write and read strobes.
 * assumes the bench owns the clock and calls the tasks hierarchically.
 */
`default_nettype none
`include "pce_params.svh"
module pce_host_model (
    // clock
    input wire logic clock,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // idle address, and after a write the data, are inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask : rd
    // key write must come straight before the protected write
    task automatic unlock_wr(input logic [7:0] d);
        wr(`PCE_ADDR_KEY, `PCE_UNLOCK_VALUE);
        wr(`PCE_ADDR_ENABLE, d);
    endtask : unlock_wr
endmodule : pce_host_model
`default_nettype wire

// ===== tb/tb_top.sv
/*
 * self-checking bench of the register slice; expected read data is queued
 * and compared by a monitor with the read results. assumes pce_pkg and the host model.
 */
`default_nettype none
`include "pce_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic power_fail_out_n = 1'b1;
    logic seq_update = 1'b0;
    logic [4:0] seq_rail_en = 5'h00;
    logic wake_pulse = 1'b0;
    logic wake_from_suspend = 1'b0;
    logic [7:0] suspend_en_snapshot = 8'h00;
    logic freshness_seal = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, cell_acquire_start, power_off, unlocked;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
    logic [5:0] rail_enable;
    pce_pkg::pce_byte_t q[$];
    int miscompares = 0;
    int total_checks = 0;
    int i;
    always #5 clock = ~clock;
    pce_host_model pce_host_model_inst (.clock(clock), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    pce_regs pce_regs_inst (.clock(clock), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .power_fail_out_n(power_fail_out_n), .seq_update(seq_update),
        .seq_rail_en(seq_rail_en), .wake_pulse(wake_pulse),
        .wake_from_suspend(wake_from_suspend),
        .suspend_en_snapshot(suspend_en_snapshot),
        .freshness_seal(freshness_seal), .rail_enable(rail_enable),
        .cell_acquire_start(cell_acquire_start), .power_off(power_off),
        .unlocked(unlocked));
    task automatic check(input pce_pkg::pce_byte_t got,
                         input pce_pkg::pce_byte_t exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    always @(negedge clock) begin
        if (reg_rvalid === 1'b1) begin
            check(reg_rdata, (q.size() != 0) ? q.pop_front() : 8'hEE);
        end
    end
    task automatic rdx(input logic [7:0] a, input pce_pkg::pce_byte_t e);
        q.push_back(e);
        pce_host_model_inst.rd(a);
    endtask : rdx
    task automatic wake(input logic s);
        @(posedge clock);
        wake_from_suspend <= s;
        wake_pulse <= 1'b1;
        @(posedge clock);
        wake_pulse <= 1'b0;
    endtask : wake
    task automatic seq(input logic [4:0] v);
        @(posedge clock);
        seq_rail_en <= v;
        seq_update <= 1'b1;
        @(posedge clock);
        seq_update <= 1'b0;
    endtask : seq
    task automatic print_verdict;
        for (i = 0; i < 20 && q.size() != 0; i++) @(posedge clock);
        if (q.size() != 0) miscompares++;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        r = 8'($urandom(32'hF1F5)) | 8'h01;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rdx(`PCE_ADDR_CTRL, 8'h00);
        rdx(`PCE_ADDR_FLAGS, 8'h00);
        pce_host_model_inst.wr(`PCE_ADDR_KEY, r);
        #1 check({7'h00, unlocked}, 8'h00);
        rdx(`PCE_ADDR_KEY, 8'h00);
        pce_host_model_inst.wr(`PCE_ADDR_ENABLE, 8'hFF);
        rdx(`PCE_ADDR_ENABLE, 8'h00);
        pce_host_model_inst.wr(`PCE_ADDR_KEY, `PCE_UNLOCK_VALUE);
        #1 check({7'h00, unlocked}, 8'h01);
        rdx(`PCE_ADDR_KEY, 8'h00);
        pce_host_model_inst.wr(`PCE_ADDR_ENABLE, 8'hFF);
        #1 check({7'h00, unlocked}, 8'h00);
        rdx(`PCE_ADDR_ENABLE, 8'h3F);
        check({2'h0, rail_enable}, 8'h3F);
        $display("test reset_and_unlock done");
        freshness_seal <= 1'b1;
        pce_host_model_inst.unlock_wr(8'h00);
        rdx(`PCE_ADDR_ENABLE, 8'h30);
        freshness_seal <= 1'b0;
        pce_host_model_inst.unlock_wr(8'h00);
        rdx(`PCE_ADDR_ENABLE, 8'h00);
        seq(r[4:0]);
        rdx(`PCE_ADDR_ENABLE, {3'h0, r[4:0]});
        $display("test seal_and_sequencer done");
        pce_host_model_inst.wr(`PCE_ADDR_CTRL, 8'h01);
        #1 check({7'h00, cell_acquire_start}, 8'h01);
        @(posedge clock);
        #1 check({7'h00, cell_acquire_start}, 8'h00);
        rdx(`PCE_ADDR_CTRL, 8'h00);
        r = 8'($urandom);
        suspend_en_snapshot <= r;
        wake(1'b1);
        pce_host_model_inst.wr(`PCE_ADDR_FLAGS, ~r);
        rdx(`PCE_ADDR_FLAGS, r);
        wake(1'b0);
        rdx(`PCE_ADDR_FLAGS, 8'h00);
        $display("test acquire_and_flags done");
        pce_host_model_inst.wr(`PCE_ADDR_CTRL, 8'h02);
        rdx(`PCE_ADDR_CTRL, 8'h02);
        power_fail_out_n <= 1'b0;
        for (i = 0; i < 20 && power_off !== 1'b1; i++) @(negedge clock);
        check({1'b0, power_off, rail_enable}, 8'h40);
        @(posedge clock);
        power_fail_out_n <= 1'b1;
        repeat (6) @(posedge clock);
        wake(1'b0);
        #1 check({7'h00, power_off}, 8'h00);
        pce_host_model_inst.wr(`PCE_ADDR_CTRL, 8'h00);
        seq(5'h1F);
        power_fail_out_n <= 1'b0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        check({1'b0, power_off, rail_enable}, 8'h1F);
        $display("test power_fail done");
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
